// File: common/tmv_edge_if.sv
// Interface carrying the edge events of one synchronised pin.
// Assumes the detector and its user share one clock.
interface tmv_edge_if;
    logic rise;
    logic fall;

    modport det (output rise, output fall);
    modport user (input rise, input fall);
endinterface

// File: common/tmv_pkg.sv
// Package for the timer V control block: register map, field layout,
// reset values and mode encodings.
// Assumes a 32-bit AXI4-Lite register bus and an 8-bit counter.
package tmv_pkg;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [5:0] OFS_CONTROL = 6'h00;
    localparam logic [5:0] OFS_CONTROL_EXT = 6'h04;
    localparam logic [5:0] OFS_STATUS = 6'h08;
    localparam logic [5:0] OFS_COUNT = 6'h0c;
    localparam logic [5:0] OFS_CMP_A = 6'h10;
    localparam logic [5:0] OFS_CMP_B = 6'h14;
    localparam int ADDR_W = 6;

    // ************************************************************
    // Control register fields
    // ************************************************************
    localparam int POS_CLK_SEL = 0;
    localparam int POS_CLR_SEL = 3;
    localparam int POS_OVF_IE = 5;
    localparam int POS_MFA_IE = 6;
    localparam int POS_MFB_IE = 7;
    localparam int POS_CLK_EXT = 0;

    // Status bit positions, same layout used for the interrupt gate
    localparam int POS_ST_OVF = 0;
    localparam int POS_ST_MFA = 1;
    localparam int POS_ST_MFB = 2;
    localparam int ST_W = 3;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_CMP = 8'hff;
    localparam logic [6:0] PRESC_W_ONES = 7'h7f;
    localparam int PRESC_W = 7;

    // ************************************************************
    // Mode encodings
    // ************************************************************
    typedef enum logic [2:0] {
        CKS_OFF = 3'h0,
        CKS_INT_A = 3'h1,
        CKS_INT_B = 3'h2,
        CKS_INT_C = 3'h3,
        CKS_OFF2 = 3'h4,
        CKS_EXT_RISE = 3'h5,
        CKS_EXT_FALL = 3'h6,
        CKS_EXT_BOTH = 3'h7
    } tmv_cks_t;

    typedef enum logic [1:0] {
        CLR_NONE = 2'h0,
        CLR_MATCH_A = 2'h1,
        CLR_MATCH_B = 2'h2,
        CLR_EXT_RST = 2'h3
    } tmv_clr_t;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: rtl/tmv_edge_sync.sv
// Two-flop synchroniser with edge detection for one external pin.
// Assumes the pin is asynchronous to clk; events lag the pin by 2 edges.
module tmv_edge_sync
(
    input wire logic clk,
    input wire logic srst,
    input wire logic pin,
    tmv_edge_if.det ev
);

    logic meta_q;
    logic sync_q;
    logic prev_q;

    // ************************************************************
    // Synchroniser and history
    // ************************************************************
    // First flop feeds only the second, to keep metastability contained
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            meta_q <= pin;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Edge pulses, one cycle each
    assign ev.rise = sync_q & ~prev_q;
    assign ev.fall = ~sync_q & prev_q;

endmodule // tmv_edge_sync

// File: rtl/tmv_top.sv
// Timer V control block: control register, 8-bit counter with clock
// select, clearing modes, compare flags and interrupt gating.
// Assumes a 25 MHz MCLK as the system clock and an AXI4-Lite master.
//
// Summary of operation
// - Clock select 000 gives no count clock; the counter holds.
// - Internal prescaled sources advance the counter on their falling edge.
// - Clear select 00 never clears the counter; it only wraps on overflow.
// - Clear select 01 clears on match A, 10 clears on match B.
// - Clear select 11 clears on a rising edge of the external reset pin.
// - Overflow enable gates the overflow flag onto an interrupt request.
// - Match A enable at 0 blocks any request from the match A flag.
// - Match A enable at 1 lets a set match A flag request an interrupt.
// - External selections count on rising, falling or both pin edges.
//
// Chosen here: the AXI4-Lite register port and the register addresses.
module tmv_top
(
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic [5:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [5:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic TMR_CLK_PIN,
    input wire logic TMR_RST_PIN,
    output logic IRQ,
    output logic OVERFLOW_IRQ,
    output logic MATCH_A_IRQ
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [7:0] timer_v_control_q;
    logic timer_v_control_ext_q;
    logic [7:0] count_q;
    logic [7:0] cmp_a_q;
    logic [7:0] cmp_b_q;
    logic [tmv_pkg::ST_W-1:0] status_q;
    logic [tmv_pkg::ST_W-1:0] status_d;
    logic [tmv_pkg::PRESC_W-1:0] presc_q;
    logic upd_q;
    logic irq_q;
    logic ovf_irq_q;
    logic mfa_irq_q;

    logic [5:0] aw_addr_q;
    logic aw_full_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic w_full_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    logic wr_go;
    logic wr_lane0;
    logic [tmv_pkg::ST_W-1:0] st_clr;
    logic [tmv_pkg::ST_W-1:0] st_set;
    logic [tmv_pkg::ST_W-1:0] irq_gate;
    logic [tmv_pkg::PRESC_W-1:0] tap_mask;
    logic tick;
    logic ovf_ev;
    logic mfa_ev;
    logic mfb_ev;
    logic clr_ev;
    logic [31:0] rd_mux;
    logic rd_ok;

    tmv_pkg::tmv_cks_t cks;
    tmv_pkg::tmv_clr_t clr_sel;

    tmv_edge_if clk_pin_ev ();
    tmv_edge_if rst_pin_ev ();

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    tmv_edge_sync u_clk_pin
    (
        .clk(MCLK),
        .srst(SRST),
        .pin(TMR_CLK_PIN),
        .ev(clk_pin_ev.det)
    );

    tmv_edge_sync u_rst_pin
    (
        .clk(MCLK),
        .srst(SRST),
        .pin(TMR_RST_PIN),
        .ev(rst_pin_ev.det)
    );

    // ************************************************************
    // AXI4-Lite write channels
    // ************************************************************
    // Address and data are held apart so either may come first
    assign S_AXI_AWREADY = ~aw_full_q & ~bvalid_q;
    assign S_AXI_WREADY = ~w_full_q & ~bvalid_q;
    assign wr_go = aw_full_q & w_full_q & ~bvalid_q;
    assign wr_lane0 = wr_go & w_strb_q[0];

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            aw_full_q <= 1'b0;
            aw_addr_q <= 6'h00;
        end
        else if (S_AXI_AWVALID && S_AXI_AWREADY)
        begin
            aw_full_q <= 1'b1;
            aw_addr_q <= S_AXI_AWADDR;
        end
        else if (wr_go)
        begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            w_full_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end
        else if (S_AXI_WVALID && S_AXI_WREADY)
        begin
            w_full_q <= 1'b1;
            w_data_q <= S_AXI_WDATA;
            w_strb_q <= S_AXI_WSTRB;
        end
        else if (wr_go)
        begin
            w_full_q <= 1'b0;
        end
    end

    // Response one cycle after both halves are held
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= tmv_pkg::RESP_OKAY;
        end
        else if (wr_go)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= addr_ok(aw_addr_q) ? tmv_pkg::RESP_OKAY : tmv_pkg::RESP_SLVERR;
        end
        else if (S_AXI_BREADY)
        begin
            bvalid_q <= 1'b0;
        end
    end

    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;

    function automatic logic addr_ok(input logic [5:0] a);
        addr_ok = (a == tmv_pkg::OFS_CONTROL) || (a == tmv_pkg::OFS_CONTROL_EXT)
            || (a == tmv_pkg::OFS_STATUS) || (a == tmv_pkg::OFS_COUNT)
            || (a == tmv_pkg::OFS_CMP_A) || (a == tmv_pkg::OFS_CMP_B);
    endfunction

    // ************************************************************
    // Software registers
    // ************************************************************
    // Control bits reset to zero: clock off, interrupts off
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            timer_v_control_q <= tmv_pkg::RST_CONTROL;
            timer_v_control_ext_q <= 1'b0;
            cmp_a_q <= tmv_pkg::RST_CMP;
            cmp_b_q <= tmv_pkg::RST_CMP;
        end
        else if (wr_lane0)
        begin
            if (aw_addr_q == tmv_pkg::OFS_CONTROL)
                timer_v_control_q <= w_data_q[7:0];
            if (aw_addr_q == tmv_pkg::OFS_CONTROL_EXT)
                timer_v_control_ext_q <= w_data_q[tmv_pkg::POS_CLK_EXT];
            if (aw_addr_q == tmv_pkg::OFS_CMP_A)
                cmp_a_q <= w_data_q[7:0];
            if (aw_addr_q == tmv_pkg::OFS_CMP_B)
                cmp_b_q <= w_data_q[7:0];
        end
    end

    assign cks = tmv_pkg::tmv_cks_t'(timer_v_control_q[tmv_pkg::POS_CLK_SEL +: 3]);
    assign clr_sel = tmv_pkg::tmv_clr_t'(timer_v_control_q[tmv_pkg::POS_CLR_SEL +: 2]);

    // ************************************************************
    // Prescaler and count clock select
    // ************************************************************
    // Free running, so the tap phase never depends on select changes
    always_ff @(posedge MCLK)
    begin
        if (SRST)
            presc_q <= '0;
        else
            presc_q <= presc_q + 1'b1;
    end

    // Divider 4..128: tap bit k falls when bits k..0 are all ones
    always_comb
    begin
        tap_mask = '0;
        unique case (cks)
            tmv_pkg::CKS_INT_A: tap_mask = timer_v_control_ext_q ? 7'h07 : 7'h03;
            tmv_pkg::CKS_INT_B: tap_mask = timer_v_control_ext_q ? 7'h1f : 7'h0f;
            tmv_pkg::CKS_INT_C: tap_mask = timer_v_control_ext_q ? 7'h7f : 7'h3f;
            tmv_pkg::CKS_OFF, tmv_pkg::CKS_OFF2, tmv_pkg::CKS_EXT_RISE,
            tmv_pkg::CKS_EXT_FALL, tmv_pkg::CKS_EXT_BOTH: tap_mask = '0;
        endcase
    end

    always_comb
    begin
        tick = 1'b0;
        unique case (cks)
            tmv_pkg::CKS_OFF, tmv_pkg::CKS_OFF2: tick = 1'b0;
            tmv_pkg::CKS_INT_A, tmv_pkg::CKS_INT_B, tmv_pkg::CKS_INT_C:
                tick = &(presc_q | ~tap_mask);
            tmv_pkg::CKS_EXT_RISE: tick = clk_pin_ev.rise;
            tmv_pkg::CKS_EXT_FALL: tick = clk_pin_ev.fall;
            tmv_pkg::CKS_EXT_BOTH: tick = clk_pin_ev.rise | clk_pin_ev.fall;
        endcase
    end

    // ************************************************************
    // Counter
    // ************************************************************
    // Compare is judged on the value just taken, so a held value
    // does not raise the match flag again every cycle
    assign mfa_ev = upd_q & (count_q == cmp_a_q);
    assign mfb_ev = upd_q & (count_q == cmp_b_q);
    assign ovf_ev = tick & (count_q == 8'hff);

    always_comb
    begin
        clr_ev = 1'b0;
        unique case (clr_sel)
            tmv_pkg::CLR_NONE: clr_ev = 1'b0;
            tmv_pkg::CLR_MATCH_A: clr_ev = mfa_ev;
            tmv_pkg::CLR_MATCH_B: clr_ev = mfb_ev;
            tmv_pkg::CLR_EXT_RST: clr_ev = rst_pin_ev.rise;
        endcase
    end

    // Clear wins over a count in the same cycle
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            count_q <= 8'h00;
            upd_q <= 1'b0;
        end
        else if (wr_lane0 && aw_addr_q == tmv_pkg::OFS_COUNT)
        begin
            count_q <= w_data_q[7:0];
            upd_q <= 1'b0;
        end
        else if (clr_ev)
        begin
            count_q <= 8'h00;
            upd_q <= 1'b0;
        end
        else
        begin
            count_q <= count_q + {7'h00, tick}; // Wraps to 00 on overflow
            upd_q <= tick;
        end
    end

    // ************************************************************
    // Status flags and interrupts
    // ************************************************************
    // Write one to clear; a same-cycle event keeps the bit set
    assign st_set = {mfb_ev, mfa_ev, ovf_ev};
    assign st_clr = (wr_lane0 && aw_addr_q == tmv_pkg::OFS_STATUS)
        ? w_data_q[tmv_pkg::ST_W-1:0] : '0;
    assign status_d = (status_q & ~st_clr) | st_set;

    always_ff @(posedge MCLK)
    begin
        if (SRST)
            status_q <= '0;
        else
            status_q <= status_d;
    end

    // Enable bits act as the interrupt mask
    assign irq_gate[tmv_pkg::POS_ST_OVF] = timer_v_control_q[tmv_pkg::POS_OVF_IE];
    assign irq_gate[tmv_pkg::POS_ST_MFA] = timer_v_control_q[tmv_pkg::POS_MFA_IE];
    assign irq_gate[tmv_pkg::POS_ST_MFB] = timer_v_control_q[tmv_pkg::POS_MFB_IE];

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            irq_q <= 1'b0;
            ovf_irq_q <= 1'b0;
            mfa_irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= |(status_q & irq_gate);
            ovf_irq_q <= status_q[tmv_pkg::POS_ST_OVF] & irq_gate[tmv_pkg::POS_ST_OVF];
            mfa_irq_q <= status_q[tmv_pkg::POS_ST_MFA] & irq_gate[tmv_pkg::POS_ST_MFA];
        end
    end

    assign IRQ = irq_q;
    assign OVERFLOW_IRQ = ovf_irq_q;
    assign MATCH_A_IRQ = mfa_irq_q;

    // ************************************************************
    // AXI4-Lite read channel
    // ************************************************************
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        rd_ok = 1'b1;
        unique case (S_AXI_ARADDR)
            tmv_pkg::OFS_CONTROL: rd_mux[7:0] = timer_v_control_q;
            tmv_pkg::OFS_CONTROL_EXT: rd_mux[0] = timer_v_control_ext_q;
            tmv_pkg::OFS_STATUS: rd_mux[tmv_pkg::ST_W-1:0] = status_q;
            tmv_pkg::OFS_COUNT: rd_mux[7:0] = count_q;
            tmv_pkg::OFS_CMP_A: rd_mux[7:0] = cmp_a_q;
            tmv_pkg::OFS_CMP_B: rd_mux[7:0] = cmp_b_q;
            default: rd_ok = 1'b0; // Unmapped reads give zero and an error
        endcase
    end

    assign S_AXI_ARREADY = ~rvalid_q;

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= tmv_pkg::RESP_OKAY;
        end
        else if (S_AXI_ARVALID && S_AXI_ARREADY)
        begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_ok ? tmv_pkg::RESP_OKAY : tmv_pkg::RESP_SLVERR;
        end
        else if (S_AXI_RREADY)
        begin
            rvalid_q <= 1'b0;
        end
    end

    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA = rdata_q;
    assign S_AXI_RRESP = rresp_q;

endmodule // tmv_top

// File: sim/test_timer_v_control_reg.sv
// Self-checking bench for the timer V control block over AXI4-Lite.
// Assumes tmv_top with its checker bound; pins driven directly by the bench.
module test_timer_v_control_reg;
    timeunit 1ns;
    timeprecision 1ns;
    logic MCLK, SRST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic [5:0] S_AXI_AWADDR, S_AXI_ARADDR;
    logic [31:0] S_AXI_WDATA, S_AXI_RDATA, a0, b0;
    logic [3:0] S_AXI_WSTRB;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r0;
    logic TMR_CLK_PIN, TMR_RST_PIN, IRQ, OVERFLOW_IRQ, MATCH_A_IRQ;
    int errors, checks_done, cyc;
    logic [7:0] pat [3] = '{8'ha5, 8'h5a, 8'h00};
    logic [7:0] mctl [3] = '{8'h49, 8'h09, 8'h11};
    tmv_top tmv_top_inst (.MCLK, .SRST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
        .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
        .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
        .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .TMR_CLK_PIN, .TMR_RST_PIN, .IRQ,
        .OVERFLOW_IRQ, .MATCH_A_IRQ);
    // ************************************************************
    // Clock, cycle count and hang guard
    // ************************************************************
    initial
    begin
        MCLK = 1'b0;
        forever #20 MCLK = ~MCLK;
    end
    // Non-blocking count so the main sequence always reads the pre-edge value
    always @(posedge MCLK)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errors++;
            end_of_test();
        end
    end
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g,
        input bit le = 1'b0);
        checks_done++;
        if (le ? ((g <= e) !== 1'b1) : (g !== e))
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    // Both halves offered together, each dropped as soon as it is taken
    task automatic wr(input logic [5:0] a, input logic [7:0] v,
        input logic [1:0] er = tmv_pkg::RESP_OKAY);
        bit aw;
        bit w;
        aw = 1'b0;
        w = 1'b0;
        S_AXI_AWADDR <= a;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WDATA <= {24'h000000, v};
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        while (!(aw && w))
        begin
            @(posedge MCLK);
            if (!aw && S_AXI_AWREADY === 1'b1)
            begin
                aw = 1'b1;
                S_AXI_AWVALID <= 1'b0;
            end
            if (!w && S_AXI_WREADY === 1'b1)
            begin
                w = 1'b1;
                S_AXI_WVALID <= 1'b0;
            end
        end
        do @(posedge MCLK); while (S_AXI_BVALID !== 1'b1);
        chk("write response", {30'h0, er}, {30'h0, S_AXI_BRESP});
        S_AXI_BREADY <= 1'b0;
        @(posedge MCLK);
    endtask
    task automatic rd(input logic [5:0] a, output logic [31:0] v, output logic [1:0] r);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        do @(posedge MCLK); while (S_AXI_ARREADY !== 1'b1);
        S_AXI_ARVALID <= 1'b0;
        do @(posedge MCLK); while (S_AXI_RVALID !== 1'b1);
        v = S_AXI_RDATA;
        r = S_AXI_RRESP;
        S_AXI_RREADY <= 1'b0;
        @(posedge MCLK);
    endtask
    task automatic rdc(input string nm, input logic [5:0] a, input logic [31:0] e,
        input bit le = 1'b0);
        logic [31:0] v;
        logic [1:0] r;
        rd(a, v, r);
        chk(nm, e, v, le);
    endtask
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        {SRST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 6'h21;
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB} = 48'hf;
        {TMR_CLK_PIN, TMR_RST_PIN, errors, checks_done, cyc} = '0;
        repeat (4) @(posedge MCLK);
        SRST <= 1'b0;
        @(posedge MCLK);
        // Reset value, read/write bits, unmapped place
        rdc("control at reset", tmv_pkg::OFS_CONTROL, 32'h0);
        foreach (pat[i])
        begin
            wr(tmv_pkg::OFS_CONTROL, pat[i]);
            rdc("control readback", tmv_pkg::OFS_CONTROL, {24'h0, pat[i]});
        end
        rd(6'h18, a0, r0);
        chk("unmapped data", 32'h0, a0);
        chk("unmapped resp", {30'h0, tmv_pkg::RESP_SLVERR}, {30'h0, r0});
        wr(6'h18, 8'h55, tmv_pkg::RESP_SLVERR);
        // Both disabled selections leave the counter still
        for (int c = 0; c < 8; c += 4)
        begin
            wr(tmv_pkg::OFS_CONTROL, 8'(c));
            wr(tmv_pkg::OFS_COUNT, 8'h10);
            repeat (300) @(posedge MCLK);
            rdc("held count", tmv_pkg::OFS_COUNT, 32'h10);
        end
        // Reads spaced by two prescaler periods see exactly two counts
        for (int i = 0; i < 6; i++)
        begin
            wr(tmv_pkg::OFS_CONTROL_EXT, 8'(i % 2));
            wr(tmv_pkg::OFS_CONTROL, 8'(i / 2 + 1));
            cyc_wait_read(8 << i);
        end
        wr(tmv_pkg::OFS_CONTROL_EXT, 8'h00);
        // External pin edges: rising, falling, both
        for (int m = 5; m < 8; m++)
        begin
            wr(tmv_pkg::OFS_CONTROL, 8'(m));
            wr(tmv_pkg::OFS_COUNT, 8'h00);
            repeat (3)
            begin
                TMR_CLK_PIN <= 1'b1;
                repeat (4) @(posedge MCLK);
                TMR_CLK_PIN <= 1'b0;
                repeat (4) @(posedge MCLK);
            end
            repeat (8) @(posedge MCLK);
            rdc("pin edge count", tmv_pkg::OFS_COUNT, (m == 7) ? 32'h6 : 32'h3);
        end
        // Overflow: masked, then unmasked, then cleared
        wr(tmv_pkg::OFS_CMP_A, 8'h40);
        wr(tmv_pkg::OFS_CMP_B, 8'h40);
        wr(tmv_pkg::OFS_STATUS, 8'h07);
        wr(tmv_pkg::OFS_CONTROL, 8'h01);
        wr(tmv_pkg::OFS_COUNT, 8'hfc);
        repeat (60) @(posedge MCLK);
        chk("masked overflow", 32'h0, {31'h0, OVERFLOW_IRQ | IRQ});
        rdc("status after wrap", tmv_pkg::OFS_STATUS, 32'h1);
        wr(tmv_pkg::OFS_CONTROL, 8'h21);
        repeat (2) @(posedge MCLK);
        chk("unmasked overflow", 32'h1, {31'h0, OVERFLOW_IRQ & IRQ});
        wr(tmv_pkg::OFS_STATUS, 8'h01);
        repeat (2) @(posedge MCLK);
        chk("cleared overflow", 32'h0, {31'h0, OVERFLOW_IRQ});
        wr(tmv_pkg::OFS_COUNT, 8'hfe);
        repeat (12) @(posedge MCLK);
        chk("overflow while enabled", 32'h1, {31'h0, OVERFLOW_IRQ});
        // Compare clearing and match A gating
        wr(tmv_pkg::OFS_CMP_A, 8'h08);
        wr(tmv_pkg::OFS_CMP_B, 8'h06);
        foreach (mctl[i])
        begin
            wr(tmv_pkg::OFS_CONTROL, mctl[i]);
            wr(tmv_pkg::OFS_STATUS, 8'h07);
            wr(tmv_pkg::OFS_COUNT, 8'h00);
            repeat (200) @(posedge MCLK);
            rdc("count under clear", tmv_pkg::OFS_COUNT, (i == 2) ? 32'h6 : 32'h8, 1'b1);
            chk("match A request", {31'h0, mctl[i][6]}, {31'h0, MATCH_A_IRQ});
        end
        // Reset pin clears only in clear mode 11
        for (int k = 0; k < 2; k++)
        begin
            wr(tmv_pkg::OFS_CONTROL, k ? 8'h01 : 8'h19);
            wr(tmv_pkg::OFS_COUNT, 8'h80);
            TMR_RST_PIN <= 1'b1;
            repeat (4) @(posedge MCLK);
            TMR_RST_PIN <= 1'b0;
            repeat (4) @(posedge MCLK);
            rd(tmv_pkg::OFS_COUNT, a0, r0);
            chk("count top bit", k, {31'h0, a0[7]});
        end
        end_of_test();
    end
    // Two reads started a fixed number of cycles apart
    task automatic cyc_wait_read(input int span);
        int t0;
        t0 = cyc;
        rd(tmv_pkg::OFS_COUNT, a0, r0);
        while (cyc != t0 + span)
            @(posedge MCLK);
        rd(tmv_pkg::OFS_COUNT, b0, r0);
        chk("ticks per span", 32'h2, {24'h0, b0[7:0] - a0[7:0]});
    endtask
endmodule // test_timer_v_control_reg

// File: sim/tmv_checker.sv
// Checker for the timer V control block: control shadow, interrupt gating.
// Assumes it is bound to tmv_top and sees only that module's ports.
module tmv_checker
(
    input logic MCLK,
    input logic SRST,
    input logic [5:0] S_AXI_AWADDR,
    input logic S_AXI_AWVALID,
    input logic S_AXI_AWREADY,
    input logic [31:0] S_AXI_WDATA,
    input logic [3:0] S_AXI_WSTRB,
    input logic S_AXI_WVALID,
    input logic S_AXI_WREADY,
    input logic [5:0] S_AXI_ARADDR,
    input logic S_AXI_ARVALID,
    input logic S_AXI_ARREADY,
    input logic [31:0] S_AXI_RDATA,
    input logic IRQ,
    input logic OVERFLOW_IRQ,
    input logic MATCH_A_IRQ
);
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************************
    // Control register shadow
    // ************************************************************
    logic [5:0] wa_q;
    logic [7:0] wd_q;
    logic ws_q;
    logic ha_q;
    logic hw_q;
    logic [7:0] ctl_q;
    logic wr_now;
    assign wr_now = ha_q && hw_q;
    // Mirror each write at the edge the block applies it, the one after both halves
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            ha_q <= 1'b0;
            hw_q <= 1'b0;
            ctl_q <= 8'h00;
        end
        else
        begin
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                wa_q <= S_AXI_AWADDR;
                ha_q <= 1'b1;
            end
            else if (wr_now)
                ha_q <= 1'b0;
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                wd_q <= S_AXI_WDATA[7:0];
                ws_q <= S_AXI_WSTRB[0];
                hw_q <= 1'b1;
            end
            else if (wr_now)
                hw_q <= 1'b0;
            if (wr_now && wa_q == tmv_pkg::OFS_CONTROL && ws_q)
                ctl_q <= wd_q;
        end
    end
    // ************************************************************
    // Properties
    // ************************************************************
    default clocking @(posedge MCLK); endclocking
    default disable iff (SRST);
    sequence s_ar_ctl;
        S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == tmv_pkg::OFS_CONTROL;
    endsequence
    sequence s_over_new;
        $rose(OVERFLOW_IRQ) && $past(ctl_q[5], 2);
    endsequence
    property p_over_gate; OVERFLOW_IRQ |-> $past(ctl_q[5]); endproperty
    a_over_gate: assert property (p_over_gate) else $error("overflow request while disabled");
    property p_mfa_gate; MATCH_A_IRQ |-> $past(ctl_q[6]); endproperty
    a_mfa_gate: assert property (p_mfa_gate) else $error("match A request while disabled");
    property p_irq_any; OVERFLOW_IRQ || MATCH_A_IRQ |-> IRQ; endproperty
    a_irq_any: assert property (p_irq_any) else $error("IRQ low with a request up");
    property p_over_hold; OVERFLOW_IRQ && ctl_q[5] && !$past(wr_now) |=> OVERFLOW_IRQ; endproperty
    a_over_hold: assert property (p_over_hold) else $error("overflow request dropped");
    property p_mfa_hold; MATCH_A_IRQ && ctl_q[6] && !$past(wr_now) |=> MATCH_A_IRQ; endproperty
    a_mfa_hold: assert property (p_mfa_hold) else $error("match A request dropped");
    // Counting is needed for an overflow, so the clock must have been on
    property p_over_src;
        s_over_new |-> ($past(ctl_q[1:0], 2) != 2'h0 || $past(ctl_q[1:0], 3) != 2'h0);
    endproperty
    a_over_src: assert property (p_over_src) else $error("overflow with clock off");
    property p_ctl_read; s_ar_ctl |=> S_AXI_RDATA == {24'h000000, $past(ctl_q)}; endproperty
    a_ctl_read: assert property (p_ctl_read) else $error("control read mismatch");
    property p_rst_quiet; $fell(SRST) |-> !IRQ && !OVERFLOW_IRQ && !MATCH_A_IRQ; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("request up after reset");
endmodule // tmv_checker

bind tmv_top tmv_checker tmv_checker_inst (.MCLK, .SRST, .S_AXI_AWADDR, .S_AXI_AWVALID,
    .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_ARADDR,
    .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .IRQ, .OVERFLOW_IRQ, .MATCH_A_IRQ);
